// ===== rtl/ccr_pkg.sv
// Shared constants for the charger configuration register bank
package ccr_pkg;
  localparam logic [6:0] CCR_DEV_ADDR      = 7'h4B;
  localparam int         CCR_NUM_REGS      = 6;
  localparam logic [7:0] CCR_MAX_IDX       = 8'h08;
  localparam logic [7:0] CCR_IDX_INSRC     = 8'h00;
  localparam logic [7:0] CCR_IDX_PWRON     = 8'h01;
  localparam logic [7:0] CCR_IDX_CHGCUR    = 8'h02;
  localparam logic [7:0] CCR_IDX_PRETERM   = 8'h03;
  localparam logic [7:0] CCR_IDX_CHGVOLT   = 8'h04;
  localparam logic [7:0] CCR_IDX_TERMTMR   = 8'h05;
  localparam logic [7:0] CCR_RST_INSRC     = 8'h30;
  localparam logic [7:0] CCR_RST_PWRON     = 8'h1B;
  localparam logic [7:0] CCR_RST_CHGCUR    = 8'h21;
  localparam logic [7:0] CCR_RST_PRETERM   = 8'h33;
  localparam logic [7:0] CCR_RST_CHGVOLT   = 8'hC3;
  localparam logic [7:0] CCR_RST_TERMTMR   = 8'h98;
  localparam logic [2:0] CCR_CAP_SDP_LOW   = 3'h0;
  localparam logic [2:0] CCR_CAP_SDP_HIGH  = 3'h2;
  localparam logic [2:0] CCR_CAP_DCP       = 3'h5;
  localparam int         CCR_HIZ_BIT       = 7;
  localparam int         CCR_REGRST_BIT    = 7;
  localparam int         CCR_WDKICK_BIT    = 6;
  localparam int         CCR_WDPER_LSB     = 4;
  localparam logic [1:0] CCR_WDPER_OFF     = 2'h0;
  localparam int         CCR_CLK_PERIOD_NS = 10;
  localparam int         CCR_SEC_NS        = 1000000000;
  localparam int         CCR_SEC_CYC       = CCR_SEC_NS / CCR_CLK_PERIOD_NS;
  localparam int         CCR_WD_BASE_S     = 40;
  localparam logic [3:0] CCR_BYTE_BITS     = 4'h8;
  typedef enum logic [3:0] {
    CCR_ST_IDLE  = 4'b0000,
    CCR_ST_ADDR  = 4'b0001,
    CCR_ST_AACK  = 4'b0010,
    CCR_ST_IDX   = 4'b0011,
    CCR_ST_IACK  = 4'b0100,
    CCR_ST_WDATA = 4'b0101,
    CCR_ST_WACK  = 4'b0110,
    CCR_ST_RDATA = 4'b0111,
    CCR_ST_RACK  = 4'b1000
  } ccr_state_t;
endpackage : ccr_pkg

// ===== rtl/ccr_bank.sv
// I2C target with the charger configuration registers and host watchdog
`timescale 1ns/1ps
// Operation
// - Answers as I2C target at seven-bit address 4BH; host uses it always.
// - Undefined register index gets NACK and the target returns to idle.
// - Multi-byte reads and writes over indices 00..08 with auto-increment.
// - Input register bit 7 enables high-impedance input mode; clear after reset.
// - Input voltage field bits 6:3, 3.88V plus 80mV per step, reset 0110.
// - Three-bit input current cap maps 000..111 to 100..3000 mA.
// - Input current cap default follows detected source: SDP 000/010, DCP/CDP 101.
// - Writing 1 to power-on bit 7 restores all registers to defaults.
// - Writing 1 to power-on bit 6 restarts host watchdog; host repeats it.
// - Mode bits 5:4: 00 no charge, 01 charge (reset), 1x OTG boost.
// - Minimum system voltage bits 3:1, 3V plus 0.1V per step.
// - Power-on bit 0 selects headroom 50mV or 100mV; resets to 1.
// - Fast charge current bits 7:2, 512mA plus 64mA per step, reset 001000.
// - Boost output cap bits 1:0, 00 is 500mA, 01 is 1.3A, reset 01.
// - Precharge and termination nibbles, 64mA plus 64mA per step, reset 0011.
// - Charge-full voltage bits 7:2, 3.48V plus 15mV per step, reset 110000.
// - Charge voltage bit 0 selects recharge drop 200mV or 100mV; reset 1.
// - Termination register bit 7 enables termination; register resets to 98H.
// - Termination bit 6 selects when termination is indicated.
// - Watchdog period bits 5:4: off, 40s, 80s, 160s; reset 01.
// - Charge current register reads 21H after power-on or register reset.
module ccr_bank
  import ccr_pkg::*;
#(
  parameter int SEC_CYC = CCR_SEC_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [1:0] src_type,
  output logic            hi_impedance_enable,
  output logic [3:0]      input_voltage_code,
  output logic [2:0]      input_current_cap,
  output logic [1:0]      charge_mode,
  output logic [2:0]      sys_min_code,
  output logic            sys_headroom_sel,
  output logic [5:0]      fast_charge_current,
  output logic [1:0]      boost_output_current_cap,
  output logic [3:0]      precharge_current,
  output logic [3:0]      termination_current,
  output logic [5:0]      charge_full_code,
  output logic            precharge_threshold_sel,
  output logic            recharge_drop,
  output logic            termination_enable,
  output logic            termination_indicator_mode,
  output logic [1:0]      watchdog_period,
  output logic            watchdog_expired
);

  if (SEC_CYC < 2) begin : g_sec_chk
    $error("SEC_CYC must be at least 2");
  end

  // Pin synchronisers and glitch filter
  logic [2:0] scl_s_r;
  logic [2:0] sda_s_r;
  logic       scl_f_r;
  logic       sda_f_r;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[1:0], scl_in};
      sda_s_r <= {sda_s_r[1:0], sda_in};
      if (scl_s_r[1] == scl_s_r[2]) scl_f_r <= scl_s_r[2];
      if (sda_s_r[1] == sda_s_r[2]) sda_f_r <= sda_s_r[2];
    end
  end

  logic scl_d_r;
  logic sda_d_r;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_f_r;
      sda_d_r <= sda_f_r;
    end
  end

  wire scl_rise = scl_f_r & ~scl_d_r;
  wire scl_fall = ~scl_f_r & scl_d_r;
  wire bus_start = scl_f_r & scl_d_r & sda_d_r & ~sda_f_r;
  wire bus_stop  = scl_f_r & scl_d_r & ~sda_d_r & sda_f_r;

  // Register storage and defaults
  logic [7:0] regs_r [CCR_NUM_REGS];
  logic [2:0] cap_dflt;
  assign cap_dflt = src_type[1] ? CCR_CAP_DCP :
                    (src_type[0] ? CCR_CAP_SDP_HIGH : CCR_CAP_SDP_LOW);

  ccr_state_t st_r;
  ccr_state_t st_nxt;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] idx_r;
  logic [7:0] tx_r;
  logic       rd_r;
  logic       sda_oe_r;

  wire        byte_done = scl_fall & (bit_cnt_r == CCR_BYTE_BITS);
  wire [7:0]  rx_byte   = shift_r;
  wire        addr_hit  = (rx_byte[7:1] == CCR_DEV_ADDR);
  wire        idx_ok    = (rx_byte <= CCR_MAX_IDX);
  wire        cur_ok    = (idx_r <= CCR_MAX_IDX);
  wire        cur_stored = (idx_r < 8'(CCR_NUM_REGS));
  wire [7:0]  rd_byte   = cur_stored ? regs_r[idx_r[2:0]] : 8'h00;
  wire        wr_en     = (st_r == CCR_ST_WDATA) & byte_done & cur_ok & cur_stored;
  wire        wr_pwron  = wr_en & (idx_r == CCR_IDX_PWRON);
  wire        reg_reset = wr_pwron & rx_byte[CCR_REGRST_BIT];
  wire        wd_kick   = wr_pwron & rx_byte[CCR_WDKICK_BIT];
  wire  [7:0] idx_inc   = idx_r + 8'h01;
  wire  [7:0] regs_next_rd = (idx_inc < 8'(CCR_NUM_REGS)) ? regs_r[idx_inc[2:0]] : 8'h00;

  // Transfer sequencer
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      CCR_ST_IDLE:  st_nxt = CCR_ST_IDLE;
      CCR_ST_ADDR:  if (byte_done) st_nxt = addr_hit ? CCR_ST_AACK : CCR_ST_IDLE;
      CCR_ST_AACK:  if (scl_fall) st_nxt = rd_r ? CCR_ST_RDATA : CCR_ST_IDX;
      CCR_ST_IDX:   if (byte_done) st_nxt = idx_ok ? CCR_ST_IACK : CCR_ST_IDLE;
      CCR_ST_IACK:  if (scl_fall) st_nxt = CCR_ST_WDATA;
      CCR_ST_WDATA: if (byte_done) st_nxt = cur_ok ? CCR_ST_WACK : CCR_ST_IDLE;
      CCR_ST_WACK:  if (scl_fall) st_nxt = CCR_ST_WDATA;
      CCR_ST_RDATA: if (byte_done) st_nxt = CCR_ST_RACK;
      CCR_ST_RACK: begin
        if (scl_rise && sda_f_r) st_nxt = CCR_ST_IDLE;
        else if (scl_fall) st_nxt = CCR_ST_RDATA;
      end
      default:      st_nxt = CCR_ST_IDLE;
    endcase
    if (bus_start) st_nxt = CCR_ST_ADDR;
    else if (bus_stop) st_nxt = CCR_ST_IDLE;
  end

  wire in_rx = (st_r == CCR_ST_ADDR) | (st_r == CCR_ST_IDX) | (st_r == CCR_ST_WDATA);
  wire ack_ok = (st_r == CCR_ST_ADDR) ? addr_hit :
                (st_r == CCR_ST_IDX) ? idx_ok : cur_ok;
  wire in_ack = (st_r == CCR_ST_AACK) | (st_r == CCR_ST_IACK) | (st_r == CCR_ST_WACK);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_r      <= CCR_ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
      idx_r     <= 8'h00;
      tx_r      <= 8'h00;
      rd_r      <= 1'b0;
      sda_oe_r  <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (bus_start || bus_stop) begin
        bit_cnt_r <= 4'h0;
        sda_oe_r  <= 1'b0;
      end else if (in_rx) begin
        if (scl_rise) begin
          shift_r   <= {shift_r[6:0], sda_f_r};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        if (byte_done) begin
          sda_oe_r <= ack_ok;
          if (st_r == CCR_ST_ADDR) rd_r <= rx_byte[0];
          if (st_r == CCR_ST_IDX) idx_r <= rx_byte;
        end
      end else if (in_ack && scl_fall) begin
        bit_cnt_r <= 4'h0;
        if (st_r == CCR_ST_WACK) idx_r <= idx_r + 8'h01;
        if (st_r == CCR_ST_AACK && rd_r) begin
          tx_r     <= rd_byte;
          sda_oe_r <= ~rd_byte[7];
        end else begin
          sda_oe_r <= 1'b0;
        end
      end else if (st_r == CCR_ST_RDATA) begin
        if (scl_rise) bit_cnt_r <= bit_cnt_r + 4'h1;
        if (byte_done) begin
          sda_oe_r <= 1'b0;
        end else if (scl_fall) begin
          tx_r     <= {tx_r[6:0], 1'b0};
          sda_oe_r <= ~tx_r[6];
        end
      end else if (st_r == CCR_ST_RACK && scl_fall) begin
        bit_cnt_r <= 4'h0;
        idx_r     <= idx_r + 8'h01;
        tx_r      <= regs_next_rd;
        sda_oe_r  <= ~regs_next_rd[7];
      end
    end
  end

  // Register writes and defaults
  always_ff @(posedge sys_clk) begin
    if (!rstn || reg_reset) begin
      regs_r[0] <= {CCR_RST_INSRC[7:3], cap_dflt};
      regs_r[1] <= CCR_RST_PWRON;
      regs_r[2] <= CCR_RST_CHGCUR;
      regs_r[3] <= CCR_RST_PRETERM;
      regs_r[4] <= CCR_RST_CHGVOLT;
      regs_r[5] <= CCR_RST_TERMTMR;
    end else if (wr_en) begin
      if (idx_r == CCR_IDX_PWRON) begin
        regs_r[1] <= {2'b00, rx_byte[5:0]};
      end else begin
        regs_r[idx_r[2:0]] <= rx_byte;
      end
    end
  end

  // Host watchdog
  logic [31:0] sec_cnt_r;
  logic [7:0]  wd_sec_r;
  logic        wd_exp_r;
  wire  [1:0]  wd_sel    = regs_r[5][CCR_WDPER_LSB +: 2];
  wire         wd_off    = (wd_sel == CCR_WDPER_OFF);
  wire  [7:0]  wd_limit  = 8'(CCR_WD_BASE_S) << (wd_sel - 2'h1);
  wire         sec_tick  = (sec_cnt_r == 32'(SEC_CYC - 1));
  wire         wd_hit    = ~wd_off & sec_tick & (wd_sec_r + 8'h01 >= wd_limit);
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sec_cnt_r <= 32'h0;
      wd_sec_r  <= 8'h00;
      wd_exp_r  <= 1'b0;
    end else begin
      if (wd_kick || wd_off || reg_reset || wd_hit) begin
        sec_cnt_r <= 32'h0;
        wd_sec_r  <= 8'h00;
      end else if (sec_tick) begin
        sec_cnt_r <= 32'h0;
        wd_sec_r  <= wd_sec_r + 8'h01;
      end else begin
        sec_cnt_r <= sec_cnt_r + 32'h1;
      end
      if (wd_hit) wd_exp_r <= 1'b1;
      else if (wd_kick) wd_exp_r <= 1'b0;
    end
  end

  // Outputs
  assign sda_out                    = 1'b0;
  assign sda_oe                     = sda_oe_r;
  assign hi_impedance_enable        = regs_r[0][CCR_HIZ_BIT];
  assign input_voltage_code         = regs_r[0][6:3];
  assign input_current_cap          = regs_r[0][2:0];
  assign charge_mode                = regs_r[1][5:4];
  assign sys_min_code               = regs_r[1][3:1];
  assign sys_headroom_sel           = regs_r[1][0];
  assign fast_charge_current        = regs_r[2][7:2];
  assign boost_output_current_cap   = regs_r[2][1:0];
  assign precharge_current          = regs_r[3][7:4];
  assign termination_current        = regs_r[3][3:0];
  assign charge_full_code           = regs_r[4][7:2];
  assign precharge_threshold_sel    = regs_r[4][1];
  assign recharge_drop              = regs_r[4][0];
  assign termination_enable         = regs_r[5][7];
  assign termination_indicator_mode = regs_r[5][6];
  assign watchdog_period            = regs_r[5][5:4];
  assign watchdog_expired           = wd_exp_r;

  // Checks
  addr_ack_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st_r == CCR_ST_ADDR && byte_done && addr_hit && !bus_start && !bus_stop)
      |=> (sda_oe && st_r == CCR_ST_AACK))
    else $error("address match not acknowledged");
  bad_idx_nack_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st_r == CCR_ST_IDX && byte_done && !idx_ok && !bus_start && !bus_stop)
      |=> (!sda_oe && st_r == CCR_ST_IDLE))
    else $error("undefined index not refused");
  idx_step_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st_r == CCR_ST_WACK && scl_fall && !bus_start && !bus_stop)
      |=> (idx_r == $past(idx_r) + 8'h01))
    else $error("index did not advance");
  hiz_reset_a: assert property (@(posedge sys_clk)
    !rstn |=> (!hi_impedance_enable && input_voltage_code == CCR_RST_INSRC[6:3]))
    else $error("input register reset wrong");
  cap_dflt_a: assert property (@(posedge sys_clk)
    (!rstn && src_type[1]) |=> (input_current_cap == CCR_CAP_DCP))
    else $error("source default cap wrong");
  reg_restore_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    reg_reset |=> (regs_r[2] == CCR_RST_CHGCUR && regs_r[5] == CCR_RST_TERMTMR))
    else $error("register reset did not restore defaults");
  wd_restart_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wd_kick && !wd_hit) |=> (sec_cnt_r == 32'h0 && wd_sec_r == 8'h00 && !watchdog_expired))
    else $error("watchdog not restarted");
  wd_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wd_off && !watchdog_expired) |=> !watchdog_expired)
    else $error("disabled watchdog expired");
  self_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $past(wr_pwron) |-> (regs_r[1][7:6] == 2'b00))
    else $error("control bits did not self clear");
  foreign_addr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st_r == CCR_ST_ADDR && byte_done && !addr_hit && !bus_start && !bus_stop)
      |=> (!sda_oe && st_r == CCR_ST_IDLE))
    else $error("foreign address acknowledged");
  stop_idle_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    bus_stop
      |=> (!sda_oe && st_r == CCR_ST_IDLE))
    else $error("stop did not return to idle");
  wr_ack_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st_r == CCR_ST_WDATA && byte_done && cur_ok && !bus_start && !bus_stop)
      |=> (sda_oe && st_r == CCR_ST_WACK))
    else $error("write byte not acknowledged");
  wr_nack_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st_r == CCR_ST_WDATA && byte_done && !cur_ok && !bus_start && !bus_stop)
      |=> (!sda_oe && st_r == CCR_ST_IDLE))
    else $error("write past last index not refused");
  rd_release_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st_r == CCR_ST_RDATA && byte_done && !bus_start && !bus_stop)
      |=> (!sda_oe && st_r == CCR_ST_RACK))
    else $error("read byte not released for host answer");
  rd_nack_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st_r == CCR_ST_RACK && scl_rise && sda_f_r && !bus_start && !bus_stop)
      |=> (st_r == CCR_ST_IDLE))
    else $error("host refusal did not end the read");
  insrc_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wr_en && idx_r == CCR_IDX_INSRC)
      |=> (hi_impedance_enable == $past(rx_byte[CCR_HIZ_BIT])))
    else $error("input register write did not land");
  chgcur_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wr_en && idx_r == CCR_IDX_CHGCUR)
      |=> (fast_charge_current == $past(rx_byte[7:2])))
    else $error("charge current write did not land");
  pwron_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wr_pwron && !reg_reset)
      |=> (regs_r[1] == {2'b00, $past(rx_byte[5:0])}))
    else $error("power-on register write wrong");
  wd_expire_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    wd_hit
      |=> watchdog_expired)
    else $error("watchdog expiry not flagged");
  wd_sticky_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (watchdog_expired && !wd_kick)
      |=> watchdog_expired)
    else $error("expiry flag dropped without restart");
  wd_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    wd_off
      |=> (wd_sec_r == 8'h00 && sec_cnt_r == 32'h0))
    else $error("disabled watchdog kept counting");

endmodule : ccr_bank

// ===== verif/ccr_host.sv
// Host-side I2C master model that drives the register bank
`timescale 1ns/1ps
module ccr_host
  import ccr_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic dev_oe,
  output logic      scl_line,
  output logic      sda_line
);
  logic sda_low_r;
  initial begin
    scl_line  = 1'b1;
    sda_low_r = 1'b0;
  end
  // Open-drain data wire with pull-up
  assign sda_line = !(sda_low_r || dev_oe);
  task automatic half();
    repeat (12) @(posedge sys_clk);
  endtask : half
  task automatic start();
    sda_low_r <= 1'b0;
    half();
    scl_line <= 1'b1;
    half();
    sda_low_r <= 1'b1;
    half();
    scl_line <= 1'b0;
    half();
  endtask : start
  task automatic stop();
    sda_low_r <= 1'b1;
    half();
    scl_line <= 1'b1;
    half();
    sda_low_r <= 1'b0;
    half();
  endtask : stop
  task automatic bit_io(input logic b, output logic s);
    sda_low_r <= !b;
    half();
    scl_line <= 1'b1;
    half();
    s = sda_line;
    scl_line <= 1'b0;
    half();
  endtask : bit_io
  task automatic tx(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask : tx
  task automatic rx(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask : rx
  // Acks shift in oldest first: address, index, then each data byte
  task automatic wr(input logic [6:0] adr, input logic [7:0] idx, input logic [7:0] d [$],
                    output logic [11:0] acks);
    logic a;
    acks = '0;
    start();
    tx({adr, 1'b0}, a);
    acks = {acks[10:0], a};
    tx(idx, a);
    acks = {acks[10:0], a};
    foreach (d[i]) begin
      tx(d[i], a);
      acks = {acks[10:0], a};
    end
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] idx, input int n, output logic [7:0] q [$]);
    logic       a;
    logic [7:0] b;
    q = {};
    start();
    tx({CCR_DEV_ADDR, 1'b0}, a);
    tx(idx, a);
    start();
    tx({CCR_DEV_ADDR, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      rx(i == n - 1, b);
      q.push_back(b);
    end
    stop();
  endtask : rd
endmodule : ccr_host

// ===== verif/tb_top.sv
// Self-checking bench for the charger configuration register bank
`timescale 1ns/1ps
module tb_top;
  import ccr_pkg::*;
  localparam int SEC = 20;
  logic        sys_clk  = 1'b0;
  logic        rstn     = 1'b0;
  logic [1:0]  src_type = 2'h2;
  wire         scl_line, sda_line, sda_oe, wd_exp;
  wire  [7:0]  o0, o1, o2, o3, o4, o5;
  logic [7:0]  mdl [0:5];
  logic [7:0]  lf = 8'h05;
  logic [7:0]  q [$];
  logic [11:0] acks;
  int          n_fail = 0;
  int          checks = 0;
  always #5 sys_clk = ~sys_clk;
  ccr_host u_host (.sys_clk(sys_clk), .dev_oe(sda_oe), .scl_line(scl_line),
                   .sda_line(sda_line));
  ccr_bank #(.SEC_CYC(SEC)) u_dut (
    .sys_clk(sys_clk), .rstn(rstn), .scl_in(scl_line), .sda_in(sda_line), .sda_out(),
    .sda_oe(sda_oe), .src_type(src_type), .hi_impedance_enable(o0[7]),
    .input_voltage_code(o0[6:3]), .input_current_cap(o0[2:0]), .charge_mode(o1[5:4]),
    .sys_min_code(o1[3:1]), .sys_headroom_sel(o1[0]), .fast_charge_current(o2[7:2]),
    .boost_output_current_cap(o2[1:0]), .precharge_current(o3[7:4]),
    .termination_current(o3[3:0]), .charge_full_code(o4[7:2]),
    .precharge_threshold_sel(o4[1]), .recharge_drop(o4[0]), .termination_enable(o5[7]),
    .termination_indicator_mode(o5[6]), .watchdog_period(o5[5:4]),
    .watchdog_expired(wd_exp));
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nxt
  // Expected readback: control bits of reg01 read 0, indices past 05 read 0
  function automatic logic [7:0] rb(input int i);
    return (i == 1) ? (mdl[1] & 8'h3F) : (i < 6) ? mdl[i] : 8'h00;
  endfunction : rb
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    if (n_fail == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic defaults(input logic [2:0] cap);
    mdl = '{{5'h06, cap}, 8'h1B, 8'h21, 8'h33, 8'hC3, 8'h98};
  endtask : defaults
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask : do_reset
  task automatic chk_all();
    chk("reg00 out", o0, mdl[0]);
    chk("reg01 out", {2'h0, o1[5:0]}, rb(1));
    chk("reg02 out", o2, mdl[2]);
    chk("reg03 out", o3, mdl[3]);
    chk("reg04 out", o4, mdl[4]);
    chk("reg05 out", {o5[7:4], 4'h0}, mdl[5] & 8'hF0);
    u_host.rd(8'h00, 9, q);
    foreach (q[i]) chk("readback", q[i], rb(i));
  endtask : chk_all
  task automatic wd_run(input logic [1:0] per, input int lim);
    int n;
    n = 0;
    mdl[5] = {2'h2, per, 4'h8};
    u_host.wr(CCR_DEV_ADDR, 8'h05, {mdl[5]}, acks);
    u_host.wr(CCR_DEV_ADDR, 8'h01, {8'h5B}, acks);
    chk("expired after restart", {7'h00, wd_exp}, 8'h00);
    repeat (lim - 150) @(posedge sys_clk);
    chk("expired early", {7'h00, wd_exp}, 8'h00);
    while (per != 2'h0 && wd_exp !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    chk("expired", {7'h00, wd_exp}, {7'h00, per != 2'h0});
  endtask : wd_run
  initial begin
    @(posedge sys_clk);
    for (int s = 0; s < 3; s++) begin
      src_type <= s[1:0];
      do_reset();
      defaults(s == 0 ? 3'h0 : s == 1 ? 3'h2 : 3'h5);
      chk("source cap", {5'h00, o0[2:0]}, {5'h00, mdl[0][2:0]});
    end
    chk_all();
    for (int r = 0; r < 3; r++) begin
      q = {};
      for (int i = 0; i < 6; i++) begin
        lf = nxt(lf);
        q.push_back(i == 1 ? lf & 8'h7F : lf);
        mdl[i] = q[i];
      end
      u_host.wr(CCR_DEV_ADDR, 8'h00, q, acks);
      chk("write acks", acks[7:0], 8'hFF);
      chk_all();
    end
    lf = nxt(lf);
    mdl[5] = lf;
    u_host.wr(CCR_DEV_ADDR, 8'h05, {lf, 8'h11, 8'h22, 8'h33, 8'h44}, acks);
    chk("acks past end", acks[7:0], 8'h7E);
    u_host.wr(7'h4C, 8'h00, {8'hFF}, acks);
    chk("foreign address", acks[7:0], 8'h00);
    u_host.wr(CCR_DEV_ADDR, 8'h09, {8'hFF}, acks);
    chk("undefined index", acks[7:0], 8'h04);
    chk_all();
    src_type <= 2'h1;
    u_host.wr(CCR_DEV_ADDR, 8'h01, {8'hBF}, acks);
    defaults(3'h2);
    chk_all();
    wd_run(2'h1, 40 * SEC);
    wd_run(2'h2, 80 * SEC);
    wd_run(2'h3, 160 * SEC);
    wd_run(2'h0, 1000);
    close_out();
  end
  initial begin
    repeat (95000) @(posedge sys_clk);
    n_fail++;
    close_out();
  end
endmodule : tb_top
